// ==== hw/psb_pkg.sv ====
package psb_pkg;
  localparam int NG = 2;
  localparam int PADS = 32;
  localparam int AW = 8;
  localparam logic [7:0] GROUP_STRIDE = 8'h80;
  localparam int GROUP_BIT = 7;
  localparam logic [6:0] OFS_LEVEL = 7'h20;
  localparam logic [6:0] OFS_POLICY = 7'h24;
  localparam logic [6:0] OFS_BULK = 7'h28;
  localparam logic [31:0] POLICY_RST = 32'h0000_0000;
  localparam logic [31:0] LEVEL_RST = 32'h0000_0000;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [3:0] FUNC_RST = 4'h0;
  localparam logic [3:0] FUNC_MAX = 4'h8;
  localparam int BIT_HALF = 31;
  localparam int BIT_APPLY_SETUP = 30;
  localparam int BIT_APPLY_FUNC = 28;
  localparam int FUNC_LSB = 24;
  localparam int BIT_STRONG = 22;
  localparam int BIT_RES = 18;
  localparam int BIT_RCV = 17;
  localparam int BIT_ROUTE = 16;
  localparam int MASK_LSB = 0;
  localparam int SET_STRONG = 6;
  localparam int SET_RES = 2;
  localparam int SET_RCV = 1;
  localparam int SET_ROUTE = 0;
  localparam logic [3:0] FULL_STRB = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== hw/psb_port_sampling.sv ====
`timescale 1ns/1ps
// Contract
// RULE1 - each pad level bit follows the sampled pad: low gives 0, high 1
// RULE2 - capture policy bit 0 means on-demand sampling, 1 continuous sampling
// RULE3 - samplers switch per byte; any policy bit set runs whole byte
// RULE4 - bulk setup register is write-only and always reads zero
// RULE5 - byte or halfword writes to bulk setup register are ignored
// RULE6 - half select 0 targets pads 0..15, 1 targets pads 16..31
// RULE7 - apply pad setup loads drive, resistor, receiver, route into pads
// RULE8 - apply function select writes function code into selected pads
// RULE9 - function code field bits 27:24 supply the stored function value
// RULE10 - bits 18,17,16 give resistor, receiver and route enable values
// RULE11 - strong drive bit of bulk write loads drive strength of pads
// RULE12 - access guard blocks writes to capture policy and bulk setup
// RULE13 - each pad group has own registers at 0x80 address stride
// RULE14 - mask bits 15:0 pick pads of chosen half; 0 leaves unchanged
// RULE15 - function codes 0x0..0x8 select functions A..I; rest reserved
// RULE16 - setup byte: drive bit 6, resistor 2, receiver 1, route 0
// RULE17 - both apply bits update setup and function in one write
// RULE18 - capture policy resets to zero, all pads on-demand
module psb_port_sampling (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [psb_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [psb_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [psb_pkg::NG-1:0] access_guard,
  input wire logic [psb_pkg::NG*psb_pkg::PADS-1:0] pad_in,
  output logic [psb_pkg::NG*psb_pkg::PADS-1:0] pad_level,
  output logic [psb_pkg::NG*4-1:0] sampler_on,
  output logic [psb_pkg::NG*psb_pkg::PADS*8-1:0] pad_setup,
  output logic [psb_pkg::NG*psb_pkg::PADS*4-1:0] pad_function
);
  import psb_pkg::*;

  logic [NG*PADS-1:0] pad_meta;
  logic [NG*PADS-1:0] pad_sync;
  logic [NG*PADS-1:0] fresh;
  logic [31:0] policy [NG];
  logic aw_held;
  logic w_held;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic do_write;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic rd_go;
  logic next_rvalid;
  logic wr_aligned;
  logic wr_hit_policy;
  logic wr_hit_bulk;
  logic wr_guarded;
  logic wr_ok_policy;
  logic wr_ok_bulk;
  logic rd_aligned;
  logic [6:0] rd_ofs;
  logic rd_level;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [1:0] next_bresp;
  logic [7:0] bulk_setup;
  logic bulk_func_ok;
  logic [NG-1:0] wr_group;
  logic [NG-1:0] rd_group;

  // pads are asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_meta <= '0;
      pad_sync <= '0;
    end else if (ce) begin
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
    end
  end

  // write channel: address and data taken in either order
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign next_aw_held = do_write ? 1'b0 :
    (aw_held | (s_axi_awvalid & s_axi_awready));
  assign next_w_held = do_write ? 1'b0 :
    (w_held | (s_axi_wvalid & s_axi_wready));
  assign next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (ce) begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
    end
  end

  // ready drops while a word is held or an answer waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= ~next_aw_held & ~next_bvalid;
      s_axi_wready <= ~next_w_held & ~next_bvalid;
    end
  end

  // group picked by the stride bit, offset by the low bits
  assign wr_aligned = (wr_addr[1:0] == 2'b00); // RULE13
  assign wr_hit_policy = wr_aligned && (wr_addr[6:0] == OFS_POLICY);
  assign wr_hit_bulk = wr_aligned && (wr_addr[6:0] == OFS_BULK);
  assign wr_guarded = access_guard[wr_addr[GROUP_BIT]]; // RULE12
  assign wr_ok_policy = do_write & wr_hit_policy & ~wr_guarded; // RULE12
  // partial strobes must not leave pads half updated
  assign wr_ok_bulk = do_write & wr_hit_bulk & ~wr_guarded
    & (wr_strb == FULL_STRB); // RULE5

  // guarded or unmapped writes answer with an error
  always_comb begin
    next_bresp = RESP_SLVERR;
    if ((wr_hit_policy || wr_hit_bulk) && !wr_guarded) begin
      next_bresp = RESP_OKAY;
    end
  end

  // one decoded word feeds every selected pad on one edge
  always_comb begin
    bulk_setup = SETUP_RST; // RULE16
    bulk_setup[SET_STRONG] = wr_data[BIT_STRONG]; // RULE11
    bulk_setup[SET_RES] = wr_data[BIT_RES]; // RULE10
    bulk_setup[SET_RCV] = wr_data[BIT_RCV]; // RULE10
    bulk_setup[SET_ROUTE] = wr_data[BIT_ROUTE]; // RULE10
  end

  // reserved codes are dropped so a pad never routes nowhere
  assign bulk_func_ok = wr_data[BIT_APPLY_FUNC]
    && (wr_data[FUNC_LSB +: 4] <= FUNC_MAX); // RULE8 RULE15

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      s_axi_bvalid <= next_bvalid;
      if (do_write) begin
        s_axi_bresp <= next_bresp;
      end
    end
  end

  // read channel
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign next_rvalid = rd_go | (s_axi_rvalid & ~s_axi_rready);
  assign rd_aligned = (s_axi_araddr[1:0] == 2'b00);
  assign rd_ofs = s_axi_araddr[6:0];
  assign rd_level = rd_go && rd_aligned && (rd_ofs == OFS_LEVEL);

  // unmapped offsets answer an error with zero data
  always_comb begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    if (!rd_aligned) begin
      next_rresp = RESP_SLVERR;
    end else begin
      case (rd_ofs)
        OFS_LEVEL: begin
          // on-demand pads are sampled by this very read
          next_rdata = fresh[{s_axi_araddr[GROUP_BIT], 5'h0} +: 32]; // RULE2
        end
        OFS_POLICY: begin
          next_rdata = policy[s_axi_araddr[GROUP_BIT]];
        end
        OFS_BULK: begin
          next_rdata = '0; // RULE4
        end
        default: begin
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (rd_go) begin
        s_axi_rresp <= next_rresp;
        s_axi_rdata <= next_rdata;
      end
    end
  end

  genvar g;
  genvar b;
  genvar p;
  generate
    for (g = 0; g < NG; g++) begin : grp
      logic [3:0] byte_on;

      assign wr_group[g] = (wr_addr[GROUP_BIT] == 1'(g)); // RULE13
      assign rd_group[g] = (s_axi_araddr[GROUP_BIT] == 1'(g)); // RULE13

      // byte strobes let software change one policy byte alone
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          policy[g] <= POLICY_RST; // RULE18
        end else if (ce && wr_ok_policy && wr_group[g]) begin
          for (int k = 0; k < 4; k++) begin
            if (wr_strb[k]) begin
              policy[g][k*8 +: 8] <= wr_data[k*8 +: 8];
            end
          end
        end
      end

      for (b = 0; b < 4; b++) begin : sub
        assign byte_on[b] = |policy[g][b*8 +: 8]; // RULE3

        // registered so the sampler switch sees no glitch
        always_ff @(posedge aclk) begin
          if (!aresetn) begin
            sampler_on[g*4+b] <= 1'b0;
          end else if (ce) begin
            sampler_on[g*4+b] <= byte_on[b]; // RULE3
          end
        end
      end

      for (p = 0; p < PADS; p++) begin : pad
        localparam int IDX = g*PADS + p;
        logic sel;
        logic rcv;

        assign rcv = pad_setup[IDX*8+SET_RCV];
        // a disabled receiver keeps its last level
        assign fresh[IDX] = rcv ? pad_sync[IDX] : pad_level[IDX]; // RULE1

        // continuous bytes follow every edge, on-demand ones only a read
        always_ff @(posedge aclk) begin
          if (!aresetn) begin
            pad_level[IDX] <= LEVEL_RST[p];
          end else if (ce && (byte_on[p/8] ||
              (rd_level && rd_group[g]))) begin
            pad_level[IDX] <= fresh[IDX]; // RULE1 RULE2 RULE3
          end
        end

        // half select and mask bit pick the pad
        assign sel = wr_ok_bulk && wr_group[g]
          && (wr_data[BIT_HALF] == 1'(p / 16)) // RULE6
          && wr_data[MASK_LSB + (p % 16)]; // RULE14

        // setup and function change on the same edge
        always_ff @(posedge aclk) begin
          if (!aresetn) begin
            pad_setup[IDX*8 +: 8] <= SETUP_RST;
          end else if (ce && sel && wr_data[BIT_APPLY_SETUP]) begin // RULE7
            pad_setup[IDX*8 +: 8] <= bulk_setup; // RULE17
          end
        end

        always_ff @(posedge aclk) begin
          if (!aresetn) begin
            pad_function[IDX*4 +: 4] <= FUNC_RST;
          end else if (ce && sel && bulk_func_ok) begin // RULE8
            pad_function[IDX*4 +: 4] <= wr_data[FUNC_LSB +: 4]; // RULE9 RULE17
          end
        end
      end
    end
  endgenerate

  // pad direction is not seen here, so policy covers every pad
endmodule

// ==== dv/psb_checker.sv ====
`timescale 1ns/1ps
module psb_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [7:0] sampler_on,
  input wire logic [63:0] pad_level,
  input wire logic [511:0] pad_setup,
  input wire logic [255:0] pad_function
);
  import psb_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_quiet;
    !sampler_on[0] && !(s_axi_arvalid && s_axi_arready);
  endsequence
  function automatic logic fn_ok(logic [255:0] f);
    for (int i = 0; i < 64; i++) if (f[i*4+:4] > FUNC_MAX) return 1'b0;
    return 1'b1;
  endfunction
  a_write_answer: assert property (s_wr |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two edges after request");
  a_read_answer: assert property (s_rd |=> s_axi_rvalid)
    else $error("read answer late");
  a_bulk_zero: assert property (
    s_rd ##0 (s_axi_araddr[6:0] == OFS_BULK) |=> s_axi_rdata == 32'h0000_0000)
    else $error("bulk register read not zero");
  a_pad_cause: assert property (
    $changed({pad_setup, pad_function}) |-> s_axi_bvalid && !s_axi_bresp[1])
    else $error("pad settings changed without accepted write");
  a_setup_bits: assert property (!(|(pad_setup & ~{64{8'h47}})))
    else $error("unused setup bit set");
  a_func_range: assert property (fn_ok(pad_function))
    else $error("reserved function code stored");
  a_demand_hold: assert property (s_quiet [*2] |-> $stable(pad_level[7:0]))
    else $error("on-demand byte changed without read");
  a_policy_reset: assert property ($rose(aresetn) |-> sampler_on == 8'h00)
    else $error("samplers on after reset");
endmodule
bind psb_port_sampling psb_checker u_chk (.*);

// ==== dv/psb_port_sampling_tb_top.sv ====
`timescale 1ns/1ps
module psb_port_sampling_tb_top;
  import psb_pkg::*;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, sampler_on;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, access_guard;
  logic [63:0] pad_in, pad_level;
  logic [511:0] pad_setup, exp_set;
  logic [255:0] pad_function, exp_fn;
  logic [33:0] q_rd[$];
  logic [1:0] q_wr[$];
  int n_errors, n_tests;
  int seed = 32'h2605;
  psb_port_sampling u_dut (.*);
  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, q_rd.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, q_wr.pop_front());
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    q_wr.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    q_rd.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // expected pad state kept here, compared after every bulk write
  task automatic bulk(input bit g, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] gd);
    int p;
    logic ok;
    access_guard <= gd;
    ok = (s == FULL_STRB) && !gd[g];
    for (int i = 0; i < 16; i++) begin
      p = g * 32 + (d[BIT_HALF] ? 16 : 0) + i;
      if (ok && d[i] && d[BIT_APPLY_SETUP])
        exp_set[p*8+:8] = {1'b0, d[BIT_STRONG], 3'b000, d[18:16]};
      if (ok && d[i] && d[BIT_APPLY_FUNC] && d[27:24] <= FUNC_MAX)
        exp_fn[p*4+:4] = d[27:24];
    end
    wr({g, OFS_BULK}, d, s, gd[g] ? RESP_SLVERR : RESP_OKAY);
    chk({pad_setup === exp_set, pad_function === exp_fn}, 34'h3);
  endtask
  task automatic give_verdict;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_errors++;
    give_verdict;
  end
  initial begin
    {aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'b01000;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb, access_guard, pad_in, exp_set, exp_fn} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd({1'b0, OFS_POLICY}, {RESP_OKAY, POLICY_RST});
    rd({1'b1, OFS_BULK}, 34'h0);
    rd(8'h2c, {RESP_SLVERR, 32'h0000_0000});
    $display("test reset done");
    for (int i = 0; i < 24; i++)
      bulk(i[0], $random(seed), i % 3 == 2 ? 4'h3 : 4'hf, i[3:2]);
    for (int i = 0; i < 4; i++)
      bulk(i[1], {i[0], 31'h4002_ffff}, FULL_STRB, 2'b00);
    $display("test bulk done");
    access_guard <= 2'b01;
    wr({1'b0, OFS_POLICY}, 32'h0000_0100, FULL_STRB, RESP_SLVERR);
    chk(sampler_on, 34'h0);
    access_guard <= 2'b00;
    wr({1'b0, OFS_POLICY}, 32'h0000_0100, FULL_STRB, RESP_OKAY);
    pad_in <= {$random(seed), $random(seed)};
    repeat (4) @(posedge aclk);
    chk(sampler_on, 34'h2);
    chk(pad_level[31:0], {16'h0000, pad_in[15:8], 8'h00});
    rd({1'b0, OFS_LEVEL}, {RESP_OKAY, pad_in[31:0]});
    rd({1'b1, OFS_LEVEL}, {RESP_OKAY, pad_in[63:32]});
    rd({1'b0, OFS_POLICY}, {RESP_OKAY, 32'h0000_0100});
    $display("test sampling done");
    ce <= 1'b0;
    pad_in <= ~pad_in;
    repeat (4) @(posedge aclk);
    chk(pad_level[15:8], {~pad_in[15:8]});
    ce <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(pad_level[15:8], pad_in[15:8]);
    $display("test freeze done");
    give_verdict;
  end
endmodule
